// ---- hw/rgel_pkg.sv ----
/*
 * Constants for the reset generation event logic: event bit positions,
 * reset sequence phase lengths and the sequencer state encoding.
 * Assumes a 100 MHz system clock.
 */
package rgel_pkg;

  // Functional and destructive event sources
  localparam int NUM_FUNC        = 6;
  localparam int EV_EXR          = 0;  // External reset
  localparam int EV_SOFT         = 1;  // Software reset
  localparam int EV_PLL_FAIL     = 2;  // PLL loss of lock
  localparam int EV_LVD_MID      = 3;  // Mid low voltage detector
  localparam int EV_CLK_FAIL     = 4;  // Oscillator failure
  localparam int EV_CORE         = 5;  // Core fault
  localparam int NUM_DEST        = 2;
  localparam int DV_POR          = 0;
  localparam int DV_LVD_LOW      = 1;

  localparam logic [NUM_FUNC-1:0] FUNC_RST = 6'h00;
  localparam logic [NUM_DEST-1:0] DEST_RST = 2'h1;

  // Sequence phase times in ns, then cycles
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RESET_PHASE_ONE_NS       = 400;
  localparam int PHASE3_NS       = 200;
  localparam int SHORT_NS        = 100;
  localparam int RESET_PHASE_ONE_CYC      = (RESET_PHASE_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE3_CYC      = (PHASE3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_CYC       = (SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;

  // Clearing takes two cycles through the synchroniser
  localparam int CLR_STAGES      = 2;

  typedef enum logic [3:0] {
    RGEL_IDLE   = 4'h1,
    RGEL_RESET_PHASE_ONE = 4'h2,
    RGEL_PHASE3 = 4'h4,
    RGEL_HOLD   = 4'h8
  } rgel_state_e;

  typedef logic [CNT_W-1:0] rgel_cnt_t;

  function automatic rgel_cnt_t rgel_cycles(input int n);
    return rgel_cnt_t'(n - 1);
  endfunction

endpackage

// ---- hw/rgel_flag_clear.sv ----
/*
 * One sticky event flag with a two-stage clear path.
 * Assumes the set and clear requests come from the system clock domain.
 */
`timescale 1ns/10ps
module rgel_flag_clear #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Seq reset abort
  input  wire logic seq_abort,
  // Event and clear
  input  wire logic set_ev,
  input  wire logic clr_req,
  // Flag
  output logic      flag_ff
);
  import rgel_pkg::*;

  logic [CLR_STAGES-1:0] clr_pipe_ff;
  logic                  clr_done;
  logic                  nxt_flag;

  assign clr_done = clr_pipe_ff[CLR_STAGES-1];
  // Set wins over a clear finishing in the same cycle
  assign nxt_flag = set_ev | (flag_ff & ~clr_done);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_pipe_ff <= '0;
      flag_ff     <= RST_VAL;
    end else begin
      // A reset arriving mid-clear drops the clear, later ones work
      clr_pipe_ff <= seq_abort ? '0 : {clr_pipe_ff[CLR_STAGES-2:0], clr_req};
      flag_ff     <= nxt_flag;
    end
  end

  a_clear_two_cycles: assert property (@(posedge clk) disable iff (sys_rst)
    clr_req && !seq_abort ##1 !seq_abort && !set_ev ##1 !set_ev |=> !flag_ff)
    else $error("flag not cleared two cycles after request");

endmodule // rgel_flag_clear

// ---- hw/rgel_core.sv ----
/*
 * Reset generation event logic: records functional and destructive reset
 * events, runs the reset sequence, drives the bidirectional external reset
 * pin and gates exit from SAFE mode.
 * Assumes the reset pin input, standby wake and fault conditions come from
 * outside the clock domain; software strobes come from the same clock.
 */
`timescale 1ns/10ps
module rgel_core (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  // External reset pin
  input  wire logic                            ext_rst_n_in,
  output logic                                 ext_rst_n_out_ff,
  output logic                                 ext_rst_oe_n_ff,
  // Functional reset configuration
  input  wire logic [rgel_pkg::NUM_FUNC-1:0]   functional_reset_pin_enable_reg,
  input  wire logic [rgel_pkg::NUM_FUNC-1:0]   functional_short_sequence_select_reg,
  // Event sources
  input  wire logic                            sw_reset_req,
  input  wire logic                            pll_fail_in,
  input  wire logic                            lvd_mid_in,
  input  wire logic                            clk_fail_in,
  input  wire logic                            core_fault_in,
  input  wire logic                            lvd_low_in,
  input  wire logic                            deep_standby_mode,
  // Flag clear strobes, one bit per flag
  input  wire logic [rgel_pkg::NUM_FUNC-1:0]   func_clr,
  input  wire logic [rgel_pkg::NUM_DEST-1:0]   dest_clr,
  // SAFE mode
  input  wire logic                            safe_exit_req,
  output logic                                 safe_mode_ff,
  // Status
  output logic [rgel_pkg::NUM_FUNC-1:0]        functional_event_status_reg,
  output logic [rgel_pkg::NUM_DEST-1:0]        destructive_event_status_reg,
  output logic                                 sys_reset_out_ff
);
  import rgel_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  wire  [NSYNC-1:0] async_in = {deep_standby_mode, lvd_low_in, core_fault_in, clk_fail_in,
                                lvd_mid_in, pll_fail_in, ~ext_rst_n_in};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end

  wire pin_low  = sync2_ff[0];
  wire pll_s    = sync2_ff[1];
  wire lvdm_s   = sync2_ff[2];
  wire clkf_s   = sync2_ff[3];
  wire core_s   = sync2_ff[4];
  wire lvdl_s   = sync2_ff[5];
  wire stby_s   = sync2_ff[6];

  // ****************************************************************
  // Event decode
  // ****************************************************************
  rgel_state_e state_ff;
  rgel_state_e nxt_state;
  rgel_cnt_t   cnt_ff;
  rgel_cnt_t   nxt_cnt;
  logic        drive_ff;
  logic        nxt_drive;
  logic        pin_prev_ff;
  logic        stby_exit_ff;

  // Our own drive of the pin is not a new external event
  wire ext_edge = pin_low & ~pin_prev_ff & ~drive_ff;
  logic [NUM_FUNC-1:0] func_ev;
  assign func_ev[EV_EXR]      = ext_edge;
  assign func_ev[EV_SOFT]     = sw_reset_req;
  // PLL flag comes only from the PLL monitor, never from the detector
  assign func_ev[EV_PLL_FAIL] = pll_s & ~lvdm_s;
  assign func_ev[EV_LVD_MID]  = lvdm_s;
  assign func_ev[EV_CLK_FAIL] = clkf_s;
  assign func_ev[EV_CORE]     = core_s;
  wire [NUM_DEST-1:0] dest_ev = {lvdl_s, 1'b0};

  wire                trig      = |func_ev && state_ff == RGEL_IDLE;
  wire [NUM_FUNC-1:0] pin_en    = func_ev & functional_reset_pin_enable_reg;
  wire [NUM_FUNC-1:0] short_sel = func_ev & functional_short_sequence_select_reg;
  // Short only when every event asks for it and none wants the pin
  wire                go_short  = (short_sel == func_ev) && ~|pin_en && ~stby_s;
  // Standby exit by pin always drives; otherwise enable bit set means drive
  wire                want_pin  = |pin_en | (func_ev[EV_EXR] & stby_s);

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_drive = drive_ff;
    case (state_ff)
      RGEL_IDLE: begin
        nxt_drive = 1'b0;
        if (trig) begin
          nxt_state = go_short ? RGEL_PHASE3 : RGEL_RESET_PHASE_ONE;
          nxt_cnt   = go_short ? rgel_cycles(SHORT_CYC) : rgel_cycles(RESET_PHASE_ONE_CYC);
          nxt_drive = want_pin;
        end
      end
      RGEL_RESET_PHASE_ONE: begin
        if (cnt_ff == '0) begin
          nxt_state = RGEL_PHASE3;
          nxt_cnt   = rgel_cycles(PHASE3_CYC);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      RGEL_PHASE3: begin
        if (cnt_ff == '0) begin
          nxt_state = RGEL_HOLD;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      RGEL_HOLD: begin
        // Drive stops here; leave at once if we were driving, else wait for the pin release
        nxt_drive = 1'b0;
        if (!pin_low || drive_ff) begin
          nxt_state = RGEL_IDLE;
        end
      end
      default: begin
        nxt_state = RGEL_IDLE;
        nxt_drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff         <= RGEL_IDLE;
      cnt_ff           <= '0;
      drive_ff         <= 1'b0;
      pin_prev_ff      <= 1'b0;
      stby_exit_ff     <= 1'b0;
      ext_rst_n_out_ff <= 1'b1;
      ext_rst_oe_n_ff  <= 1'b1;
      sys_reset_out_ff <= 1'b1;
    end else begin
      state_ff         <= nxt_state;
      cnt_ff           <= nxt_cnt;
      drive_ff         <= nxt_drive;
      pin_prev_ff      <= pin_low;
      stby_exit_ff     <= trig & stby_s & func_ev[EV_EXR];
      ext_rst_n_out_ff <= 1'b0;
      ext_rst_oe_n_ff  <= ~nxt_drive;
      sys_reset_out_ff <= (nxt_state != RGEL_IDLE);
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  wire seq_abort = trig;

  genvar g;
  generate
    for (g = 0; g < NUM_FUNC; g++) begin : g_func
      rgel_flag_clear #(.RST_VAL(FUNC_RST[g])) u_flag (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .seq_abort (seq_abort),
        .set_ev    (func_ev[g]),
        .clr_req   (func_clr[g]),
        .flag_ff   (functional_event_status_reg[g])
      );
    end
    for (g = 0; g < NUM_DEST; g++) begin : g_dest
      rgel_flag_clear #(.RST_VAL(DEST_RST[g])) u_flag (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .seq_abort (seq_abort),
        .set_ev    (dest_ev[g]),
        .clr_req   (dest_clr[g]),
        .flag_ff   (destructive_event_status_reg[g])
      );
    end
  endgenerate

  // ****************************************************************
  // SAFE mode
  // ****************************************************************
  // Causes are the live conditions, not the flags software can clear
  wire safe_cause = pll_s | clkf_s | core_s | lvdm_s;
  wire nxt_safe   = safe_cause | (safe_mode_ff & ~safe_exit_req);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      safe_mode_ff <= 1'b0;
    end else begin
      safe_mode_ff <= nxt_safe;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_pin_start;
    trig && !go_short && want_pin;
  endsequence
  sequence s_drive_reset_phase_one;
    !ext_rst_oe_n_ff [*8];
  endsequence

  a_pin_over_short: assert property (@(posedge clk) disable iff (sys_rst)
    trig && |pin_en |=> !ext_rst_oe_n_ff)
    else $error("pin not driven although enabled");
  a_drive_seq: assert property (@(posedge clk) disable iff (sys_rst)
    s_pin_start |=> s_drive_reset_phase_one)
    else $error("pin drive dropped early in sequence");
  a_stby_drive: assert property (@(posedge clk) disable iff (sys_rst)
    trig && stby_s && func_ev[EV_EXR] |=> !ext_rst_oe_n_ff)
    else $error("standby exit by pin not driving pin");
  a_safe_hold: assert property (@(posedge clk) disable iff (sys_rst)
    safe_mode_ff && safe_cause |=> safe_mode_ff)
    else $error("SAFE left while cause active");
  a_safe_exit: assert property (@(posedge clk) disable iff (sys_rst)
    safe_mode_ff && safe_exit_req && !safe_cause |=> !safe_mode_ff)
    else $error("SAFE exit refused without cause");
  a_no_soft_flag: assert property (@(posedge clk) disable iff (sys_rst)
    stby_exit_ff && !$past(sw_reset_req) && !$past(functional_event_status_reg[EV_SOFT])
    |-> !functional_event_status_reg[EV_SOFT])
    else $error("soft flag set on standby pin exit");
  a_exr_flag: assert property (@(posedge clk) disable iff (sys_rst)
    ext_edge |=> functional_event_status_reg[EV_EXR])
    else $error("pin event flag not set");
  a_lvd_no_pll: assert property (@(posedge clk) disable iff (sys_rst)
    lvdm_s && !functional_event_status_reg[EV_PLL_FAIL] |=>
    !functional_event_status_reg[EV_PLL_FAIL] && functional_event_status_reg[EV_LVD_MID])
    else $error("detector event set PLL flag");

endmodule // rgel_core

// ---- tb/rgel_board_net.sv ----
/*
 * Board reset network on the bidirectional reset pin.
 * Assumes a pull-up on the pin and open-drain style pull-down drivers.
 */
`timescale 1ns/10ps
module rgel_board_net (
  // Clock
  input  wire logic clk,
  // Device side of the pin
  input  wire logic ext_rst_n_out_ff,
  input  wire logic ext_rst_oe_n_ff,
  // Resolved pin level
  output logic      pin_n
);
  logic board_low_ff = 1'b0;

  // Pull-up wins unless either party pulls low
  assign pin_n = ((!ext_rst_oe_n_ff && !ext_rst_n_out_ff) || board_low_ff) ? 1'b0 : 1'b1;

  task automatic press(input int n);
    board_low_ff <= 1'b1;
    repeat (n) @(posedge clk);
    board_low_ff <= 1'b0;
  endtask
endmodule // rgel_board_net

// ---- tb/tb_reset_generation_event_logic.sv ----
/*
 * Self-checking bench for the reset generation event logic.
 * Assumes the design package and the board network model are compiled first.
 */
`timescale 1ns/10ps
module tb_reset_generation_event_logic;
  import rgel_pkg::*;
  // Clock, reset, pin
  logic                clk, sys_rst, rst_n_out, rst_oe_n, pin_n;
  // Events and SAFE
  logic                sw_req, pll, lvd_mid, clkf, core, lvd_low, stby, safe_req, safe, sro;
  // Configuration, clears, status
  logic [NUM_FUNC-1:0] pin_en, short_sel, fclr, fes;
  logic [NUM_DEST-1:0] dclr, des;
  int                  n_mismatch, check_count, seed, m_func, m_dest, k, n;

  rgel_core dut (.clk(clk), .sys_rst(sys_rst), .ext_rst_n_in(pin_n),
    .ext_rst_n_out_ff(rst_n_out), .ext_rst_oe_n_ff(rst_oe_n),
    .functional_reset_pin_enable_reg(pin_en), .functional_short_sequence_select_reg(short_sel),
    .sw_reset_req(sw_req), .pll_fail_in(pll), .lvd_mid_in(lvd_mid), .clk_fail_in(clkf),
    .core_fault_in(core), .lvd_low_in(lvd_low), .deep_standby_mode(stby), .func_clr(fclr),
    .dest_clr(dclr), .safe_exit_req(safe_req), .safe_mode_ff(safe),
    .functional_event_status_reg(fes), .destructive_event_status_reg(des),
    .sys_reset_out_ff(sro));
  rgel_board_net board (.clk(clk), .ext_rst_n_out_ff(rst_n_out),
    .ext_rst_oe_n_ff(rst_oe_n), .pin_n(pin_n));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_idle;
    k = 0;
    tick(4);
    while (sro !== 1'b0 && k < 300) begin
      tick(1);
      k++;
    end
    if (k >= 300) chk(8'h01, 8'h00);
  endtask
  task automatic wait_drive;
    k = 0;
    while (rst_oe_n !== 1'b0 && k < 10) begin
      tick(1);
      k++;
    end
  endtask
  task automatic pulse_clr(input logic [NUM_FUNC-1:0] f, input logic [NUM_DEST-1:0] d);
    fclr <= f;
    dclr <= d;
    tick(1);
    fclr <= '0;
    dclr <= '0;
  endtask
  task automatic end_sim;
    $display("Counts: checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    tick(20000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    seed = 32'h7AB38997;
    n_mismatch = 0;
    check_count = 0;
    sys_rst = 1'b1;
    {sw_req, pll, lvd_mid, clkf, core, lvd_low, stby, safe_req} = '0;
    {pin_en, short_sel, fclr, dclr} = '0;
    tick(3);
    sys_rst <= 1'b0;
    m_func = 0;
    m_dest = 1;
    tick(2);
    chk({fes, des}, {m_func[5:0], m_dest[1:0]});
    chk(safe, 8'h00);
    $display("done: reset values");
    // Pin enable and short sequence on the same source
    pin_en <= 6'h04;
    short_sel <= 6'($random(seed)) | 6'h04;
    pll <= 1'b1;
    tick(3);
    pll <= 1'b0;
    wait_drive();
    chk({rst_oe_n, pin_n}, 8'h00);
    wait_idle();
    m_func = m_func | 4;
    chk(fes[5:1], m_func[5:1]);
    pin_en <= '0;
    $display("done: pin with short sequence");
    // Two-cycle clear, then a clear cut short by a reset
    pulse_clr(6'h04, 2'h1);
    tick(3);
    m_func = m_func & ~4;
    m_dest = 0;
    chk({fes[5:1], des}, {m_func[5:1], m_dest[1:0]});
    // Short sequence alone: no pin drive, SHORT_CYC cycles in phase three plus one hold cycle
    short_sel <= 6'h02;
    sw_req    <= 1'b1;
    tick(1);
    sw_req <= 1'b0;
    k = 0;
    tick(1);
    while (sro === 1'b1 && k < 100) begin
      chk(rst_oe_n, 8'h01);
      tick(1);
      k++;
    end
    chk(8'(k), 8'(SHORT_CYC + 1));
    pulse_clr(6'h02, 2'h0);
    sw_req <= 1'b1;
    tick(1);
    sw_req <= 1'b0;
    wait_idle();
    m_func = m_func | 2;
    chk(fes[5:1], m_func[5:1]);
    n = ($random(seed) & 63) | 2;
    pulse_clr(6'(n), 2'h0);
    tick(3);
    m_func = m_func & ~n;
    chk(fes[5:1], m_func[5:1]);
    $display("done: flag clear");
    // Mid voltage event
    lvd_mid <= 1'b1;
    tick(3);
    lvd_mid <= 1'b0;
    wait_idle();
    m_func = m_func | 8;
    chk(fes[5:1], m_func[5:1]);
    $display("done: mid voltage");
    // SAFE exit against a live cause
    core <= 1'b1;
    wait_idle();
    chk(safe, 8'h01);
    pulse_clr(6'h3F, 2'h0);
    safe_req <= 1'b1;
    tick(4);
    safe_req <= 1'b0;
    chk(safe, 8'h01);
    core <= 1'b0;
    tick(4);
    pulse_clr(6'h3F, 2'h0);
    tick(3);
    safe_req <= 1'b1;
    tick(4);
    safe_req <= 1'b0;
    m_func = 0;
    chk({safe, fes[5:1]}, {1'b0, m_func[5:1]});
    $display("done: safe exit");
    // Standby exit, board holds the pin through phase one
    wait_idle();
    stby <= 1'b1;
    tick(3);
    n = RESET_PHASE_ONE_CYC + 4 + ($unsigned($random(seed)) % 8);
    board.press(n);
    tick(2);
    chk({rst_oe_n, pin_n, sro}, 8'h01);
    wait_idle();
    stby <= 1'b0;
    m_func = 1;
    chk(fes[1:0], m_func[1:0]);
    $display("done: standby exit");
    end_sim();
  end
endmodule // tb_reset_generation_event_logic
